/* File: eeprom_pkg.sv */
// Shared constants, the group check code, and a small two-entry stream buffer.
// Assumes a single clock domain; the buffer is flushed by the owner on frame edges.

// ---------------------------------------------------------------------------
// Constants and check-code functions
// ---------------------------------------------------------------------------
package eeprom_pkg;
  localparam int ADDR_BITS = 17;
  localparam int CLK_PERIOD_NS = 50;
  // Internal write time is not fixed here; plain default, shortened in simulation
  localparam int WRITE_TIME_US = 1000;
  localparam int WRITE_CYCLES_DEF = WRITE_TIME_US * 1000 / CLK_PERIOD_NS;
  localparam int GROUP_BYTES = 4;
  localparam int PAGE_BYTES = 256;
  localparam int PAGE_GROUPS = PAGE_BYTES / GROUP_BYTES;
  localparam int CHK_W = 6;
  localparam int GRP_W = 32 + CHK_W;
  localparam int BUF_DEPTH = 2;
  localparam logic [3:0] TYPE_MEM = 4'hA;
  localparam logic [3:0] TYPE_ID = 4'hB;
  localparam int SEL_TYPE_LSB = 4;
  localparam int SEL_CS_LSB = 2;
  localparam int SEL_TOP_ADDR = 1;
  localparam int SEL_RW = 0;
  localparam int HI_LOCK_SEL_BIT = 2;
  localparam int LOCK_DATA_BIT = 1;
  localparam logic [3:0] BIT_LAST = 4'h8;
  localparam logic [3:0] ACK_SLOT = 4'h8;
  localparam logic [3:0] ACK_END = 4'h9;
  localparam logic [31:0] ERASED_WORD = 32'hFFFFFFFF;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_DEVSEL,
    ST_ADDR_HI,
    ST_ADDR_LO,
    ST_WDATA,
    ST_RDATA
  } bus_state_t;

  // Position of data bit j in a Hamming word, skipping power-of-two slots
  function automatic logic [5:0] ecc_pos(input int j);
    logic [5:0] r;
    int n;
    r = '0;
    n = 0;
    for (int q = 3; q < 39; q++) begin
      if ((q & (q - 1)) != 0) begin
        if (n == j) begin
          r = 6'(q);
        end
        n++;
      end
    end
    return r;
  endfunction : ecc_pos

  function automatic logic [CHK_W-1:0] ecc_encode(input logic [31:0] d);
    logic [CHK_W-1:0] c;
    c = '0;
    for (int j = 0; j < 32; j++) begin
      if (d[j]) begin
        c = c ^ ecc_pos(j);
      end
    end
    return c;
  endfunction : ecc_encode

  // Single flipped bit anywhere in the group is put right; a check-bit error leaves data alone
  function automatic logic [31:0] ecc_fix(input logic [GRP_W-1:0] g);
    logic [31:0] d;
    logic [CHK_W-1:0] syn;
    d = g[31:0];
    syn = g[GRP_W-1:32] ^ ecc_encode(g[31:0]);
    for (int j = 0; j < 32; j++) begin
      if (syn == ecc_pos(j)) begin
        d[j] = ~d[j];
      end
    end
    return d;
  endfunction : ecc_fix
endpackage : eeprom_pkg

// ---------------------------------------------------------------------------
// Stream buffer
// ---------------------------------------------------------------------------
module pipe_buffer #(
  parameter int W = 8,
  parameter int DEPTH = eeprom_pkg::BUF_DEPTH
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [W-1:0] slot_ff [DEPTH];
  logic [PW:0] wr_ptr_ff;
  logic [PW:0] rd_ptr_ff;
  logic [PW:0] fill;

  assign fill = wr_ptr_ff - rd_ptr_ff;
  assign in_ready = (fill != (PW+1)'(DEPTH));
  assign out_valid = (fill != '0);
  assign out_data = slot_ff[rd_ptr_ff[PW-1:0]];

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
    end else if (flush) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
    end else begin
      if (in_valid && in_ready) begin
        wr_ptr_ff <= wr_ptr_ff + 1'b1;
      end
      if (out_valid && out_ready) begin
        rd_ptr_ff <= rd_ptr_ff + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (in_valid && in_ready && !flush) begin
      slot_ff[wr_ptr_ff[PW-1:0]] <= in_data;
    end
  end
endmodule : pipe_buffer

/* File: serial_eeprom_read_and_poll.sv */
// Two-wire serial memory slave: array and identification page with group check code,
// read modes, acknowledge polling and lock probe. Bus pins are asynchronous and are
// oversampled by clk_sys; the bus clock must be at least 4 clk_sys periods per phase.

module serial_eeprom_read_and_poll #(
  parameter int ADDR_W = eeprom_pkg::ADDR_BITS,
  parameter int WRITE_CYCLES = eeprom_pkg::WRITE_CYCLES_DEF
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic scl,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n,
  input wire logic write_protect_input,
  input wire logic chip_select_bit_low,
  input wire logic chip_select_bit_high,
  output logic write_busy,
  output logic id_page_locked
);
  import eeprom_pkg::*;

  localparam int NGRP = (2 ** ADDR_W) / GROUP_BYTES;

  // ---------------------------------------------------------------------------
  // Reset release and pin synchronisers
  // ---------------------------------------------------------------------------
  logic [1:0] rst_pipe_ff;
  logic rst_n;
  logic [4:0] pin_s1_ff;
  logic [4:0] pin_s2_ff;
  logic scl_d_ff;
  logic sda_d_ff;
  logic scl_s;
  logic sda_s;
  logic wp_s;
  logic [1:0] cs_s;
  logic scl_rise;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rst_pipe_ff <= '0;
    end else begin
      rst_pipe_ff <= {rst_pipe_ff[0], 1'b1};
    end
  end
  assign rst_n = rst_pipe_ff[1];

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_ff <= 5'h1F;
      pin_s2_ff <= 5'h1F;
      scl_d_ff <= 1'b1;
      sda_d_ff <= 1'b1;
    end else begin
      pin_s1_ff <= {chip_select_bit_high, chip_select_bit_low, write_protect_input, sda_i, scl};
      pin_s2_ff <= pin_s1_ff;
      scl_d_ff <= pin_s2_ff[0];
      sda_d_ff <= pin_s2_ff[1];
    end
  end

  assign scl_s = pin_s2_ff[0];
  assign sda_s = pin_s2_ff[1];
  assign wp_s = pin_s2_ff[2];
  assign cs_s = pin_s2_ff[4:3];
  assign scl_rise = scl_s && !scl_d_ff;
  assign scl_fall = !scl_s && scl_d_ff;
  assign start_ev = scl_s && scl_d_ff && sda_d_ff && !sda_s;
  assign stop_ev = scl_s && scl_d_ff && !sda_d_ff && sda_s;

  // ---------------------------------------------------------------------------
  // Storage and decode terms
  // ---------------------------------------------------------------------------
  logic [GRP_W-1:0] mg [NGRP];
  logic [GRP_W-1:0] idg [PAGE_GROUPS];
  logic id_lock_ff;
  logic [7:0] pbuf [PAGE_BYTES];
  logic [PAGE_BYTES-1:0] pmask_ff;
  logic wr_any_ff;
  logic lock_req_ff;
  bus_state_t st_ff;
  logic [3:0] cnt_ff;
  logic [7:0] sh_ff;
  logic sda_low_ff;
  logic is_id_ff;
  logic a16_ff;
  logic [7:0] hi_ff;
  logic [ADDR_W-1:0] addr_ff;
  logic fetch_req_ff;
  logic busy_ff;
  logic [31:0] bcnt_ff;
  logic [5:0] gi;
  logic commit_en;
  logic [GRP_W-1:0] merged;
  logic [GRP_W-1:0] rd_grp;
  logic [31:0] rd_fix;
  logic [7:0] rd_byte;
  logic type_ok;
  logic cs_ok;
  logic dev_ack;
  logic data_ack;
  logic dec_ack;
  logic rx_state;
  logic dec_ev;
  logic ack_end;
  logic rd_sample;
  logic load_ev;
  logic wr_launch;
  logic [16:0] full_addr;
  logic buf_in_ready;
  logic buf_out_valid;
  logic [7:0] buf_out_data;
  logic push_ev;

  assign type_ok = (sh_ff[7:SEL_TYPE_LSB] == TYPE_MEM) || (sh_ff[7:SEL_TYPE_LSB] == TYPE_ID);
  assign cs_ok = (sh_ff[SEL_CS_LSB+1:SEL_CS_LSB] == cs_s);
  assign dev_ack = type_ok && cs_ok && !busy_ff;
  assign data_ack = is_id_ff ? !id_lock_ff : !wp_s;
  assign rx_state = (st_ff == ST_DEVSEL) || (st_ff == ST_ADDR_HI) ||
                    (st_ff == ST_ADDR_LO) || (st_ff == ST_WDATA);
  assign dec_ev = rx_state && scl_fall && (cnt_ff == ACK_SLOT);
  assign ack_end = scl_fall && (cnt_ff == ACK_END);
  assign rd_sample = (st_ff == ST_RDATA) && scl_rise && (cnt_ff == ACK_SLOT);
  // Read path never looks at write protect
  assign load_ev = ack_end && ((st_ff == ST_RDATA) || ((st_ff == ST_DEVSEL) && sh_ff[SEL_RW]));
  assign wr_launch = stop_ev && (st_ff == ST_WDATA) && (cnt_ff <= 4'h1) && wr_any_ff && !busy_ff;
  assign full_addr = {a16_ff, hi_ff, sh_ff};
  assign push_ev = fetch_req_ff && buf_in_ready;

  always_comb begin
    unique case (st_ff)
      ST_DEVSEL: dec_ack = dev_ack;
      ST_WDATA: dec_ack = data_ack;
      default: dec_ack = 1'b1;
    endcase
  end

  // ---------------------------------------------------------------------------
  // Bit-level protocol engine
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= ST_IDLE;
      cnt_ff <= '0;
      sh_ff <= '0;
      sda_low_ff <= 1'b0;
    end else if (start_ev) begin
      st_ff <= ST_DEVSEL;
      cnt_ff <= '0;
      sda_low_ff <= 1'b0;
    end else if (stop_ev) begin
      st_ff <= ST_IDLE;
      cnt_ff <= '0;
      sda_low_ff <= 1'b0;
    end else if (rx_state) begin
      if (scl_rise && cnt_ff < BIT_LAST) begin
        sh_ff <= {sh_ff[6:0], sda_s};
        cnt_ff <= cnt_ff + 4'h1;
      end else if (dec_ev) begin
        if (st_ff == ST_DEVSEL && !dev_ack) begin
          st_ff <= ST_IDLE;
        end else begin
          sda_low_ff <= dec_ack;
          cnt_ff <= ACK_END;
        end
      end else if (ack_end) begin
        cnt_ff <= '0;
        sda_low_ff <= 1'b0;
        unique case (st_ff)
          ST_DEVSEL: begin
            if (sh_ff[SEL_RW]) begin
              st_ff <= ST_RDATA;
              sh_ff <= buf_out_data;
              sda_low_ff <= !buf_out_data[7];
            end else begin
              st_ff <= ST_ADDR_HI;
            end
          end
          ST_ADDR_HI: st_ff <= ST_ADDR_LO;
          ST_ADDR_LO: st_ff <= ST_WDATA;
          default: st_ff <= ST_WDATA;
        endcase
      end
    end else if (st_ff == ST_RDATA) begin
      if (scl_rise && cnt_ff < BIT_LAST) begin
        cnt_ff <= cnt_ff + 4'h1;
      end else if (scl_fall && cnt_ff != '0 && cnt_ff < BIT_LAST) begin
        sh_ff <= {sh_ff[6:0], 1'b0};
        sda_low_ff <= !sh_ff[6];
      end else if (scl_fall && cnt_ff == ACK_SLOT) begin
        sda_low_ff <= 1'b0;
      end else if (rd_sample) begin
        if (sda_s) begin
          st_ff <= ST_IDLE;
          cnt_ff <= '0;
        end else begin
          cnt_ff <= ACK_END;
        end
      end else if (ack_end) begin
        sh_ff <= buf_out_data;
        sda_low_ff <= !buf_out_data[7];
        cnt_ff <= '0;
      end
    end
  end

  assign sda_o = 1'b0;
  assign sda_oe_n = !sda_low_ff;

  // ---------------------------------------------------------------------------
  // Address counter and write staging
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      addr_ff <= '0;
      is_id_ff <= 1'b0;
      a16_ff <= 1'b0;
      hi_ff <= '0;
      pmask_ff <= '0;
      wr_any_ff <= 1'b0;
      lock_req_ff <= 1'b0;
    end else if (busy_ff) begin
      if (bcnt_ff == 32'(WRITE_CYCLES - 1)) begin
        pmask_ff <= '0;
        wr_any_ff <= 1'b0;
        lock_req_ff <= 1'b0;
      end
    end else if (start_ev) begin
      pmask_ff <= '0;
      wr_any_ff <= 1'b0;
      lock_req_ff <= 1'b0;
    end else if (dec_ev) begin
      unique case (st_ff)
        ST_DEVSEL: begin
          if (dev_ack) begin
            is_id_ff <= (sh_ff[7:SEL_TYPE_LSB] == TYPE_ID);
            a16_ff <= sh_ff[SEL_TOP_ADDR];
          end
        end
        ST_ADDR_HI: hi_ff <= sh_ff;
        ST_ADDR_LO: begin
          if (is_id_ff) begin
            addr_ff <= ADDR_W'(sh_ff);
          end else begin
            addr_ff <= ADDR_W'(full_addr);
          end
        end
        default: begin
          if (data_ack) begin
            wr_any_ff <= 1'b1;
            if (is_id_ff && hi_ff[HI_LOCK_SEL_BIT]) begin
              lock_req_ff <= lock_req_ff | sh_ff[LOCK_DATA_BIT];
            end else begin
              pmask_ff[addr_ff[7:0]] <= 1'b1;
              addr_ff[7:0] <= addr_ff[7:0] + 8'h01;
            end
          end
        end
      endcase
    end else if (rd_sample) begin
      addr_ff <= addr_ff + 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (dec_ev && st_ff == ST_WDATA && data_ack && !busy_ff) begin
      pbuf[addr_ff[7:0]] <= sh_ff;
    end
  end

  // ---------------------------------------------------------------------------
  // Internal write cycle
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      busy_ff <= 1'b0;
      bcnt_ff <= '0;
    end else if (wr_launch) begin
      busy_ff <= 1'b1;
      bcnt_ff <= '0;
    end else if (busy_ff) begin
      if (bcnt_ff == 32'(WRITE_CYCLES - 1)) begin
        busy_ff <= 1'b0;
      end
      bcnt_ff <= bcnt_ff + 32'h1;
    end
  end

  assign write_busy = busy_ff;
  assign id_page_locked = id_lock_ff;
  assign gi = bcnt_ff[5:0];
  assign commit_en = busy_ff && (bcnt_ff < 32'(PAGE_GROUPS));

  // Old group is corrected before merging so a stored bad bit is not re-encoded
  always_comb begin
    logic [GRP_W-1:0] old_grp;
    logic [31:0] nd;
    old_grp = is_id_ff ? idg[gi] : mg[{addr_ff[ADDR_W-1:8], gi}];
    nd = ecc_fix(old_grp);
    for (int b = 0; b < GROUP_BYTES; b++) begin
      if (pmask_ff[{gi, 2'(b)}]) begin
        nd[8*b +: 8] = pbuf[{gi, 2'(b)}];
      end
    end
    merged = {ecc_encode(nd), nd};
  end

  // Non-volatile contents: no reset, erased state comes from initialisation
  initial begin
    for (int i = 0; i < NGRP; i++) begin
      mg[i] = {ecc_encode(ERASED_WORD), ERASED_WORD};
    end
    for (int i = 0; i < PAGE_GROUPS; i++) begin
      idg[i] = {ecc_encode(ERASED_WORD), ERASED_WORD};
    end
    id_lock_ff = 1'b0;
  end

  always @(posedge clk_sys) begin
    if (commit_en) begin
      if (is_id_ff) begin
        if (!id_lock_ff) begin
          idg[gi] <= merged;
        end
      end else begin
        mg[{addr_ff[ADDR_W-1:8], gi}] <= merged;
      end
    end
    if (busy_ff && bcnt_ff == '0 && lock_req_ff) begin
      id_lock_ff <= 1'b1;
    end
  end

  // ---------------------------------------------------------------------------
  // Read fetch and output buffer
  // ---------------------------------------------------------------------------
  assign rd_grp = is_id_ff ? idg[addr_ff[7:2]] : mg[addr_ff[ADDR_W-1:2]];
  assign rd_fix = ecc_fix(rd_grp);
  assign rd_byte = rd_fix[{addr_ff[1:0], 3'b000} +: 8];

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      fetch_req_ff <= 1'b0;
    end else if (start_ev || stop_ev) begin
      fetch_req_ff <= 1'b0;
    end else if ((dec_ev && st_ff == ST_DEVSEL && dev_ack && sh_ff[SEL_RW]) ||
                 (rd_sample && !sda_s)) begin
      fetch_req_ff <= 1'b1;
    end else if (push_ev) begin
      fetch_req_ff <= 1'b0;
    end
  end

  pipe_buffer #(.W(8), .DEPTH(BUF_DEPTH)) u_rd_buf (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .flush(start_ev || stop_ev),
    .in_valid(fetch_req_ff),
    .in_ready(buf_in_ready),
    .in_data(rd_byte),
    .out_valid(buf_out_valid),
    .out_ready(load_ev),
    .out_data(buf_out_data)
  );

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence busy_hold_s;
    busy_ff [*8];
  endsequence

  sequence sel_decide_s;
    dec_ev && st_ff == ST_DEVSEL;
  endsequence

  busy_nack_a: assert property (sel_decide_s and busy_ff |=> !sda_low_ff && st_ff == ST_IDLE)
    else $error("select acknowledged during write cycle");
  poll_ack_a: assert property (sel_decide_s and dev_ack |=> sda_low_ff ##1 sda_low_ff)
    else $error("ready device did not acknowledge select");
  cs_miss_a: assert property (sel_decide_s and !cs_ok |=> st_ff == ST_IDLE && !sda_low_ff)
    else $error("chip select mismatch not ignored");
  rd_step_a: assert property (rd_sample |=> addr_ff == ADDR_W'($past(addr_ff) + 1'b1))
    else $error("read did not advance counter by one");
  wrap_zero_a: assert property (rd_sample && (&addr_ff) |=> addr_ff == '0)
    else $error("counter did not wrap to zero");
  nack_idle_a: assert property (rd_sample && sda_s |=> st_ff == ST_IDLE && !sda_low_ff)
    else $error("missing master acknowledge did not end read");
  start_clear_a: assert property (start_ev && !busy_ff |=> st_ff == ST_DEVSEL && !wr_any_ff)
    else $error("start did not discard pending command");
  lock_nack_a: assert property (dec_ev && st_ff == ST_WDATA && is_id_ff && id_lock_ff |=> !sda_low_ff)
    else $error("locked page data acknowledged");
  first_bit_a: assert property (load_ev && buf_out_valid |=> sda_low_ff == !$past(buf_out_data[7]))
    else $error("read byte not presented on bus");
  write_hold_a: assert property (wr_launch |=> busy_hold_s)
    else $error("write cycle did not hold busy");
  id_load_a: assert property (dec_ev && st_ff == ST_ADDR_LO && is_id_ff |=> addr_ff == ADDR_W'($past(sh_ff)))
    else $error("page access did not load byte location");
  seq_fetch_a: assert property (rd_sample && !sda_s |=> ##[0:2] push_ev)
    else $error("next sequential byte not fetched");
endmodule : serial_eeprom_read_and_poll

/* File: i2c_master_model.sv */
// Bus master model: drives the bus clock and pulls data low, reads the wire.
// Assumes the bench resolves data with a pull-up; the clock idles high between frames.
module i2c_master_model (
  input wire logic clk_sys,
  input wire logic sda,
  output logic scl,
  output logic sda_low
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : tick
  // Data moves a clock after the bus clock falls, so it never looks like Start or Stop
  task automatic bit_x(input logic b, output logic r);
    tick(1);
    sda_low <= ~b;
    tick(3);
    scl <= 1'b1;
    tick(3);
    r = sda;
    tick(1);
    scl <= 1'b0;
  endtask : bit_x
  // Also serves as a repeated Start with the clock low
  task automatic start;
    tick(1);
    sda_low <= 1'b0;
    tick(3);
    scl <= 1'b1;
    tick(4);
    sda_low <= 1'b1;
    tick(4);
    scl <= 1'b0;
  endtask : start
  task automatic stop;
    tick(1);
    sda_low <= 1'b1;
    tick(3);
    scl <= 1'b1;
    tick(4);
    sda_low <= 1'b0;
    tick(4);
  endtask : stop
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], r);
    end
    bit_x(1'b1, r);
    ack = ~r;
  endtask : wr_byte
  task automatic rd_byte(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(1'b1, r);
      d[i] = r;
    end
    bit_x(~ack, r);
  endtask : rd_byte
endmodule : i2c_master_model

/* File: tb_serial_eeprom_read_and_poll.sv */
// Self-checking bench for the serial memory slave, driven through the master model.
// Assumes a shortened write time; the data wire has a pull-up resolved here.
module tb_serial_eeprom_read_and_poll;
  timeunit 1ns;
  timeprecision 1ns;
  import eeprom_pkg::*;
  logic clk_sys, rstn, wp, cs_lo, cs_hi, sda_o, sda_oe_n, write_busy, id_page_locked;
  logic scl, sda_low;
  wire sda;
  int fail_count, check_count;
  assign sda = !(sda_low || (!sda_oe_n && !sda_o));
  serial_eeprom_read_and_poll #(.WRITE_CYCLES(300)) dut (
    .clk_sys(clk_sys), .rstn(rstn), .scl(scl), .sda_i(sda), .sda_o(sda_o),
    .sda_oe_n(sda_oe_n), .write_protect_input(wp), .chip_select_bit_low(cs_lo),
    .chip_select_bit_high(cs_hi), .write_busy(write_busy), .id_page_locked(id_page_locked));
  i2c_master_model m (.clk_sys(clk_sys), .sda(sda), .scl(scl), .sda_low(sda_low));
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  task automatic close_out;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : close_out
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  function automatic logic [7:0] sel(input logic [3:0] t, input logic [16:0] a, input logic rw);
    return {t, cs_hi, cs_lo, a[16], rw};
  endfunction : sel
  task automatic wb(input logic [7:0] d);
    logic k;
    m.wr_byte(d, k);
    check({7'h0, k}, 8'h01);
  endtask : wb
  task automatic frame(input logic [3:0] t, input logic [16:0] a, input logic rw);
    m.start();
    wb(sel(t, a, rw));
  endtask : frame
  task automatic set_addr(input logic [3:0] t, input logic [16:0] a);
    frame(t, a, 1'b0);
    wb(a[15:8]);
    wb(a[7:0]);
  endtask : set_addr
  task automatic rd_at(input logic [3:0] t, input logic [16:0] a);
    set_addr(t, a);
    frame(t, a, 1'b1);
  endtask : rd_at
  task automatic rd_chk(input logic ack, input logic [7:0] exp);
    logic [7:0] d;
    m.rd_byte(ack, d);
    check(d, exp);
  endtask : rd_chk
  // Leaves the select accepted, so the caller continues the instruction
  task automatic poll(input logic [16:0] a);
    logic k;
    for (int n = 0; n < 64; n++) begin
      m.start();
      m.wr_byte(sel(TYPE_MEM, a, 1'b0), k);
      if (n == 0) check({7'h0, k}, 8'h00);
      if (k) return;
    end
    fail_count++;
    close_out();
  endtask : poll
  initial begin
    logic [7:0] d0, d1, lo;
    logic [16:0] a;
    logic k;
    rstn = 1'b0;
    wp = 1'b0;
    cs_lo = 1'b0;
    cs_hi = 1'b0;
    fail_count = 0;
    check_count = 0;
    void'($urandom(32'hB8CF));
    @(posedge clk_sys);
    {cs_hi, cs_lo} <= 2'($urandom);
    repeat (10) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (8) @(posedge clk_sys);
    rd_at(TYPE_MEM, 17'($urandom));
    rd_chk(1'b0, 8'hFF);
    m.stop();
    $display("done: erased read");
    lo = 8'($urandom_range(254, 2));
    a = {9'h0, lo};
    d0 = 8'($urandom) & 8'h7F;
    set_addr(TYPE_MEM, a);
    wb(d0);
    m.stop();
    repeat (2) @(posedge clk_sys);
    check({7'h0, write_busy}, 8'h01);
    poll(a);
    wb(a[15:8]);
    wb(a[7:0]);
    frame(TYPE_MEM, a, 1'b1);
    rd_chk(1'b1, d0);
    rd_chk(1'b0, 8'hFF);
    rd_chk(1'b0, 8'hFF);
    m.stop();
    $display("done: write, poll and read back");
    rd_at(TYPE_ID, {1'b1, 8'($urandom), 8'(lo - 8'h01)});
    rd_chk(1'b0, 8'hFF);
    m.stop();
    frame(TYPE_MEM, 17'h0, 1'b1);
    rd_chk(1'b0, d0);
    m.stop();
    $display("done: shared counter");
    d0 = 8'($urandom) & 8'h7F;
    d1 = 8'($urandom) & 8'h7F;
    set_addr(TYPE_MEM, 17'h1FFFE);
    wb(d0);
    wb(d1);
    m.stop();
    poll(17'h1FFFE);
    m.stop();
    wp <= 1'b1;
    rd_at(TYPE_MEM, 17'h1FFFE);
    rd_chk(1'b1, d0);
    rd_chk(1'b1, d1);
    rd_chk(1'b0, 8'hFF);
    m.stop();
    wp <= 1'b0;
    $display("done: sequential wrap");
    for (int i = 1; i < 4; i++) begin
      m.start();
      m.wr_byte({TYPE_MEM, {cs_hi, cs_lo} ^ 2'(i), 2'b01}, k);
      check({7'h0, k}, 8'h00);
      m.stop();
    end
    $display("done: chip select mismatch");
    set_addr(TYPE_ID, 17'h0);
    m.wr_byte(8'($urandom), k);
    check({7'h0, k}, 8'h01);
    m.start();
    m.stop();
    repeat (2) @(posedge clk_sys);
    check({7'h0, write_busy}, 8'h00);
    set_addr(TYPE_ID, 17'h00400);
    wb(8'h02);
    m.stop();
    poll(17'h0);
    m.stop();
    check({7'h0, id_page_locked}, 8'h01);
    set_addr(TYPE_ID, 17'h0);
    m.wr_byte(8'h00, k);
    check({7'h0, k}, 8'h00);
    m.start();
    m.stop();
    $display("done: lock probe");
    close_out();
  end
endmodule : tb_serial_eeprom_read_and_poll
